/* File: rtl/tcs_timer_sync.sv */
// Timer bus interface with synchronised core registers, sleep and clock request
`timescale 1ns/100ps
`include "tcs_cfg.svh"
// Behaviour
// - Runs in standby only with run_in_standby set
// - Interrupt wakes system; overflow event while asleep
// - On demand: drop clock request once stopped
// - Start or retrigger requests clock before counting
// - Soft reset and enable writes synchronised
// - Capture buffer valid writes synchronised
// - Control B clear/set writes synchronised
// - Count write synchronised; read needs read-sync command
// - Period and period buffer writes synchronised
// - Compare/capture and buffer writes synchronised
// - Enable set writes ones, seen in clear
// - Channel match enables at bit four upward
// - Bit one enables error interrupt
// - Bit zero enables overflow interrupt
module tcs_timer_sync #(
  parameter int NCH      = 2,
  parameter int CORE_DIV = `TCS_CORE_DIV
) (
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  // Register port
  input  wire logic [7:0]        addr_i,
  input  wire tcs_pkg::tcs_word_type wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output tcs_pkg::tcs_word_type  rdata_o,
  // System and event side
  input  wire logic              standby_i,
  input  wire logic              evt_start_i,
  output logic                   irq_o,
  output logic                   wake_o,
  output logic                   clk_req_o,
  output logic                   evt_ovf_o
);
  import tcs_pkg::*;

  localparam int NB = 7 + 2 * NCH;

  // ************************************************************
  // Reset release and core tick
  // ************************************************************
  logic            rst_q1;
  logic            rst_q2;
  logic            rst_n;
  logic [7:0]      div_q;
  logic            tick;
  logic            srst_do;

  // Soft reset reuses the release chain, so every flop sees one clean reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= ~srst_do;
      rst_q2 <= rst_q1;
    end
  end
  assign rst_n = rst_q2;

  // Divider stands in for the peripheral clock; each tick is one core edge
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
    end else begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
    end
  end
  assign tick = (div_q == 8'(CORE_DIV - 1));

  // ************************************************************
  // Register state
  // ************************************************************
  tcs_byte_type    control_a;
  logic [2:0]      ctrlb;
  logic [2:0]      cb_set;
  logic [2:0]      cb_clr;
  tcs_cmd_type     cmd_sh;
  tcs_byte_type    inten;
  tcs_byte_type    iflag;
  logic [NB-1:0]   busy;
  tcs_word_type    count_sh;
  tcs_word_type    count_rd;
  tcs_word_type    per_sh;
  tcs_word_type    period_buffer_sh;
  tcs_word_type    cc_sh    [NCH];
  tcs_word_type    ccbuf_sh [NCH];
  logic [NCH-1:0]  ccbv_clr;
  // Core side copies
  logic            core_en;
  logic            stop_q;
  logic            start_pend;
  tcs_word_type    count_q;
  tcs_word_type    per_q;
  tcs_word_type    period_buffer_q;
  tcs_word_type    cc_q     [NCH];
  tcs_word_type    ccbuf_q  [NCH];
  logic [NCH-1:0]  ccbufv;

  // Write-one-set / write-one-clear helper; the set term always wins
  function automatic tcs_byte_type tcs_flag(input tcs_byte_type old_v,
                                            input tcs_byte_type set_v,
                                            input tcs_byte_type clr_v);
    tcs_flag = (old_v & ~clr_v) | set_v;
  endfunction : tcs_flag

  // ************************************************************
  // Address decode
  // ************************************************************
  logic [NB-1:0]   wr_hit;
  logic [NB-1:0]   wr_take;
  logic            wr_control_a;
  logic            wr_iec;
  logic            wr_ies;
  logic            wr_ifl;
  logic            refused;

  assign wr_control_a = wr_i && (addr_i == `TCS_OFS_CONTROL_A);
  assign wr_iec   = wr_i && (addr_i == `TCS_OFS_IECLR);
  assign wr_ies   = wr_i && (addr_i == `TCS_OFS_IESET);
  assign wr_ifl   = wr_i && (addr_i == `TCS_OFS_IFLAG);

  // One hit bit per synchronised register
  always_comb begin
    wr_hit = '0;
    wr_hit[`TCS_SB_SOFT_RESET_BIT]  = wr_control_a && wdata_i[`TCS_CA_SOFT_RESET_BIT];
    wr_hit[`TCS_SB_EN]     = wr_control_a;
    wr_hit[`TCS_SB_CTRLB]  = wr_i && ((addr_i == `TCS_OFS_CBCLR) ||
                                      (addr_i == `TCS_OFS_CBSET));
    wr_hit[`TCS_SB_STATUS] = wr_i && (addr_i == `TCS_OFS_STATUS);
    wr_hit[`TCS_SB_COUNT]  = wr_i && (addr_i == `TCS_OFS_COUNT);
    wr_hit[`TCS_SB_PER]    = wr_i && (addr_i == `TCS_OFS_PER);
    wr_hit[`TCS_SB_PERIOD_BUFFER] = wr_i && (addr_i == `TCS_OFS_PERIOD_BUFFER);
    for (int i = 0; i < NCH; i++) begin
      wr_hit[`TCS_SB_CC0 + i]       = wr_i && (addr_i == `TCS_OFS_CC0 + 8'(i));
      wr_hit[`TCS_SB_CC0 + NCH + i] = wr_i && (addr_i == `TCS_OFS_CCBUF0 + 8'(i));
    end
  end
  // A write to a register other than Control A whose transfer is still pending is dropped
  assign wr_take = wr_hit & ~busy;
  assign refused = |(wr_hit & busy);

  // ************************************************************
  // Synchronisation busy and shadows
  // ************************************************************
  // Busy rises with the write and falls on the core edge that accepts it
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      busy <= '0;
    end else begin
      busy <= (busy & ~{NB{tick}}) | wr_take;
    end
  end
  assign srst_do = tick && busy[`TCS_SB_SOFT_RESET_BIT];

  // Bus-side shadows catch written values until the core edge
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      count_sh  <= `TCS_RST_WORD;
      per_sh    <= `TCS_RST_WORD;
      period_buffer_sh <= `TCS_RST_WORD;
      cb_set    <= 3'b000;
      cb_clr    <= 3'b000;
      cmd_sh    <= TCS_CMD_NONE;
      ccbv_clr  <= '0;
    end else begin
      if (wr_take[`TCS_SB_COUNT])  count_sh  <= wdata_i;
      if (wr_take[`TCS_SB_PER])    per_sh    <= wdata_i;
      if (wr_take[`TCS_SB_PERIOD_BUFFER]) period_buffer_sh <= wdata_i;
      if (wr_take[`TCS_SB_STATUS]) begin
        ccbv_clr <= wdata_i[`TCS_ST_CCBUFV0 +: NCH];
      end
      if (wr_take[`TCS_SB_CTRLB]) begin
        cb_set <= (addr_i == `TCS_OFS_CBSET) ? wdata_i[2:0] : 3'b000;
        cb_clr <= (addr_i == `TCS_OFS_CBCLR) ? wdata_i[2:0] : 3'b000;
        cmd_sh <= (addr_i == `TCS_OFS_CBSET) ?
                  tcs_cmd_type'(wdata_i[`TCS_CB_CMD_LSB +: 3]) : TCS_CMD_NONE;
      end
    end
  end

  // Channel shadows
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        cc_sh[i]    <= `TCS_RST_WORD;
        ccbuf_sh[i] <= `TCS_RST_WORD;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_take[`TCS_SB_CC0 + i]) cc_sh[i] <= wdata_i;
        if (wr_take[`TCS_SB_CC0 + NCH + i]) ccbuf_sh[i] <= wdata_i;
      end
    end
  end

  // Control A reads back at once; only enable and soft reset wait for the core edge
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      control_a <= `TCS_RST_BYTE;
    end else if (wr_control_a) begin
      control_a <= wdata_i[7:0];
    end
  end

  // ************************************************************
  // Core side
  // ************************************************************
  logic            run_ok;
  logic            cnt_tick;
  logic            ovf_hit;
  logic [NCH-1:0]  mc_hit;
  logic            do_cmd;
  logic            do_load;
  logic            go;

  assign run_ok   = !standby_i || control_a[`TCS_CA_RSBY];
  assign cnt_tick = tick && core_en && !stop_q && clk_req_o && run_ok;
  assign ovf_hit  = cnt_tick && (count_q == per_q);
  assign do_cmd   = tick && busy[`TCS_SB_CTRLB];
  assign do_load  = (do_cmd && (cmd_sh == TCS_CMD_UPDATE)) ||
                    (ovf_hit && !ctrlb[`TCS_CB_LUPD]);
  // Start only once the clock request has already been standing
  assign go       = tick && start_pend && clk_req_o && core_en;
  always_comb begin
    for (int i = 0; i < NCH; i++) mc_hit[i] = cnt_tick && (count_q == cc_q[i]);
  end

  // Enable, control B and command handling on the core edge
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      core_en    <= 1'b0;
      ctrlb      <= 3'b000;
      start_pend <= 1'b0;
      stop_q     <= 1'b1;
      count_rd   <= `TCS_RST_WORD;
    end else begin
      if (tick && busy[`TCS_SB_EN]) core_en <= control_a[`TCS_CA_EN];
      if (do_cmd) ctrlb <= (ctrlb & ~cb_clr) | cb_set;
      if (do_cmd && (cmd_sh == TCS_CMD_READ_SYNC_COMMAND)) count_rd <= count_q;
      if (evt_start_i || (tick && busy[`TCS_SB_EN] && control_a[`TCS_CA_EN]) ||
          (do_cmd && (cmd_sh == TCS_CMD_RETRIGGER))) begin
        start_pend <= 1'b1;
      end else if (go) begin
        start_pend <= 1'b0;
      end
      if (go) begin
        stop_q <= 1'b0;
      end else if ((do_cmd && (cmd_sh == TCS_CMD_STOP)) || !core_en ||
                   (ovf_hit && ctrlb[`TCS_CB_ONESHOT])) begin
        stop_q <= 1'b1;
      end
    end
  end

  // Counter and period, with buffered period loaded on update
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      count_q  <= `TCS_RST_WORD;
      per_q    <= `TCS_RST_WORD;
      period_buffer_q <= `TCS_RST_WORD;
    end else begin
      if (tick && busy[`TCS_SB_COUNT]) count_q <= count_sh;
      else if (go || ovf_hit) count_q <= `TCS_RST_WORD;
      else if (cnt_tick) count_q <= count_q + 16'h0001;
      if (tick && busy[`TCS_SB_PER]) per_q <= per_sh;
      else if (do_load) per_q <= period_buffer_q;
      if (tick && busy[`TCS_SB_PERIOD_BUFFER]) period_buffer_q <= period_buffer_sh;
    end
  end

  // Compare channels; a valid buffer moves into compare on update
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ccbufv <= '0;
      for (int i = 0; i < NCH; i++) begin
        cc_q[i]    <= `TCS_RST_WORD;
        ccbuf_q[i] <= `TCS_RST_WORD;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (tick && busy[`TCS_SB_CC0 + i]) cc_q[i] <= cc_sh[i];
        else if (do_load && ccbufv[i]) cc_q[i] <= ccbuf_q[i];
        if (tick && busy[`TCS_SB_CC0 + NCH + i]) begin
          ccbuf_q[i] <= ccbuf_sh[i];
          ccbufv[i]  <= 1'b1;
        end else if ((do_load && ccbufv[i]) ||
                     (tick && busy[`TCS_SB_STATUS] && ccbv_clr[i])) begin
          ccbufv[i]  <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // Interrupts and outputs
  // ************************************************************
  tcs_byte_type    evt_vec;
  tcs_byte_type    next_inten;
  tcs_word_type    rd_mux;
  logic            next_irq;
  logic            next_req;

  always_comb begin
    evt_vec = 8'h00;
    evt_vec[`TCS_IRQ_OVF] = ovf_hit;
    evt_vec[`TCS_IRQ_ERR] = refused;
    evt_vec[`TCS_IRQ_MC0 +: NCH] = mc_hit;
  end
  // Enable set and clear share one register; writing zeros changes nothing
  assign next_inten = tcs_flag(inten, wr_ies ? wdata_i[7:0] : 8'h00,
                               wr_iec ? wdata_i[7:0] : 8'h00);
  assign next_irq   = |(iflag & inten);
  // On demand drops the request once stopped unless a start is waiting
  assign next_req   = core_en && (!control_a[`TCS_CA_OND] || !stop_q ||
                                  start_pend);

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      inten <= `TCS_RST_BYTE;
      iflag <= `TCS_RST_BYTE;
    end else begin
      inten <= next_inten;
      iflag <= tcs_flag(iflag, evt_vec, wr_ifl ? wdata_i[7:0] : 8'h00);
    end
  end

  // Read multiplexer; unmapped indices read as zero
  always_comb begin
    rd_mux = 16'h0000;
    unique case (addr_i)
      `TCS_OFS_CONTROL_A:  rd_mux = {8'h00, control_a};
      `TCS_OFS_CBCLR,
      `TCS_OFS_CBSET:  rd_mux = {13'h0000, ctrlb};
      `TCS_OFS_IECLR,
      `TCS_OFS_IESET:  rd_mux = {8'h00, inten};
      `TCS_OFS_IFLAG:  rd_mux = {8'h00, iflag};
      `TCS_OFS_STATUS: rd_mux = 16'({ccbufv, 3'b000, stop_q});
      `TCS_OFS_SBUSY:  rd_mux = 16'(busy);
      `TCS_OFS_COUNT:  rd_mux = count_rd;
      `TCS_OFS_PER:    rd_mux = per_q;
      `TCS_OFS_PERIOD_BUFFER: rd_mux = period_buffer_q;
      default: begin
        for (int i = 0; i < NCH; i++) begin
          if (addr_i == `TCS_OFS_CC0 + 8'(i)) rd_mux = cc_q[i];
          if (addr_i == `TCS_OFS_CCBUF0 + 8'(i)) rd_mux = ccbuf_q[i];
        end
      end
    endcase
  end

  // Every output is a flop; wake follows the interrupt while in standby
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o   <= `TCS_RST_WORD;
      irq_o     <= 1'b0;
      wake_o    <= 1'b0;
      clk_req_o <= 1'b0;
      evt_ovf_o <= 1'b0;
    end else begin
      rdata_o   <= rd_i ? rd_mux : `TCS_RST_WORD;
      irq_o     <= next_irq;
      wake_o    <= next_irq && standby_i;
      clk_req_o <= next_req;
      evt_ovf_o <= ovf_hit;
    end
  end

endmodule : tcs_timer_sync

/* File: rtl/tcs_cfg.svh */
// Register map, field positions, reset values and timing counts of the timer sync block
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH
// ************************************************************
// Register indices
// ************************************************************
`define TCS_OFS_CONTROL_A   8'h00
`define TCS_OFS_CBCLR   8'h04
`define TCS_OFS_CBSET   8'h05
`define TCS_OFS_IECLR   8'h08
`define TCS_OFS_IESET   8'h09
`define TCS_OFS_IFLAG   8'h0A
`define TCS_OFS_STATUS  8'h0B
`define TCS_OFS_SBUSY   8'h0C
`define TCS_OFS_COUNT   8'h10
`define TCS_OFS_PER     8'h14
`define TCS_OFS_PERIOD_BUFFER  8'h15
`define TCS_OFS_CC0     8'h18
`define TCS_OFS_CCBUF0  8'h1C
// ************************************************************
// Field positions
// ************************************************************
`define TCS_CA_SOFT_RESET_BIT    0
`define TCS_CA_EN       1
`define TCS_CA_RSBY     6
`define TCS_CA_OND      7
`define TCS_CB_LUPD     1
`define TCS_CB_ONESHOT  2
`define TCS_CB_CMD_LSB  5
`define TCS_IRQ_OVF     0
`define TCS_IRQ_ERR     1
`define TCS_IRQ_MC0     4
`define TCS_ST_STOP     0
`define TCS_ST_CCBUFV0  4
`define TCS_SB_SOFT_RESET_BIT    0
`define TCS_SB_EN       1
`define TCS_SB_CTRLB    2
`define TCS_SB_STATUS   3
`define TCS_SB_COUNT    4
`define TCS_SB_PER      5
`define TCS_SB_PERIOD_BUFFER   6
`define TCS_SB_CC0      7
// ************************************************************
// Reset values and timing
// ************************************************************
`define TCS_RST_BYTE    8'h00
`define TCS_RST_WORD    16'h0000
`define TCS_CORE_DIV    4
`endif

/* File: rtl/tcs_pkg.sv */
// Types shared by the timer sync block
package tcs_pkg;
  // Commands written through the control B set register
  typedef enum logic [2:0] {
    TCS_CMD_NONE      = 3'b000,
    TCS_CMD_RETRIGGER = 3'b001,
    TCS_CMD_STOP      = 3'b010,
    TCS_CMD_UPDATE    = 3'b011,
    TCS_CMD_READ_SYNC_COMMAND  = 3'b100
  } tcs_cmd_type;
  typedef logic [15:0] tcs_word_type;
  typedef logic [7:0]  tcs_byte_type;
endpackage : tcs_pkg

/* File: testbench/tcs_timer_sync_sva.sv */
// Port checker of the timer sync block
`timescale 1ns/100ps
module tcs_timer_sync_chk #(
  parameter int NCH      = 2,
  parameter int CORE_DIV = 4
) (
  // Clock and reset
  input wire logic                  clk_sys_i,
  input wire logic                  rst_n_i,
  // Register port
  input wire logic [7:0]            addr_i,
  input wire tcs_pkg::tcs_word_type wdata_i,
  input wire logic                  wr_i,
  input wire logic                  rd_i,
  input wire tcs_pkg::tcs_word_type rdata_o,
  // System side
  input wire logic                  standby_i,
  input wire logic                  evt_start_i,
  input wire logic                  irq_o,
  input wire logic                  wake_o,
  input wire logic                  clk_req_o,
  input wire logic                  evt_ovf_o
);
  import tcs_pkg::*;
  // ****************************************
  // Helpers and properties
  // ****************************************
  localparam logic [7:0] EN_MASK = 8'h03 | 8'(((1 << NCH) - 1) << 4);
  localparam int         REQ_WIN = 3 * CORE_DIV + 4;
  logic [7:0] quiet;
  logic       rsby;
  // Cycles since a write, start or overflow; saturates so it never wraps
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiet <= 8'h00;
      rsby  <= 1'b0;
    end else begin
      quiet <= (wr_i || evt_start_i || evt_ovf_o) ? 8'h00 : quiet + {7'h00, quiet != 8'hFF};
      if (wr_i && addr_i == 8'h00) begin
        rsby <= wdata_i[6] & ~wdata_i[0];
      end
    end
  end
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero outside a read answer");
  enset_seen_a: assert property (wr_i && addr_i == 8'h09 ##2 rd_i && addr_i == 8'h08
    |=> (rdata_o[7:0] & $past(wdata_i[7:0], 3)) == ($past(wdata_i[7:0], 3) & EN_MASK))
    else $error("enable set bits not seen in enable clear");
  wake_link_a: assert property (wake_o == (irq_o && $past(standby_i)))
    else $error("wake output disagrees with interrupt and standby");
  ovf_pulse_a: assert property (evt_ovf_o |=> !evt_ovf_o)
    else $error("overflow event longer than one cycle");
  ovf_clk_a: assert property (evt_ovf_o |-> $past(clk_req_o))
    else $error("overflow without clock request");
  req_cause_a: assert property ($rose(clk_req_o) |-> quiet <= REQ_WIN)
    else $error("clock request rose without a start cause");
  req_drop_a: assert property ($fell(clk_req_o) |-> quiet <= REQ_WIN)
    else $error("clock request fell without a stop cause");
  stby_halt_a: assert property (standby_i && $past(standby_i) && $past(standby_i, 2)
    && $past(standby_i, 3) && !$past(rsby) |-> !evt_ovf_o)
    else $error("overflow in standby without run in standby");
endmodule : tcs_timer_sync_chk
bind tcs_timer_sync tcs_timer_sync_chk #(.NCH(NCH), .CORE_DIV(CORE_DIV)) i_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .standby_i(standby_i),
  .evt_start_i(evt_start_i), .irq_o(irq_o), .wake_o(wake_o), .clk_req_o(clk_req_o),
  .evt_ovf_o(evt_ovf_o));

/* File: testbench/tcs_evt_model.sv */
// Sleep controller and event source model at the timer's system side
`timescale 1ns/100ps
module tcs_evt_model (
  // Clock
  input  wire logic clk_sys_i,
  // Sleep and event outputs
  output logic      standby_o,
  output logic      evt_start_o
);
  // Awake and quiet until told otherwise
  initial begin
    standby_o   = 1'b0;
    evt_start_o = 1'b0;
  end
  // Standby level changes just after an edge
  task automatic set_standby(input logic v);
    @(posedge clk_sys_i);
    standby_o <= v;
  endtask : set_standby
  // One-cycle start event, since every high cycle counts
  task automatic fire_start();
    @(posedge clk_sys_i);
    evt_start_o <= 1'b1;
    @(posedge clk_sys_i);
    evt_start_o <= 1'b0;
  endtask : fire_start
endmodule : tcs_evt_model

/* File: testbench/tcs_timer_sync_bench.sv */
// Self-checking bench of the timer sync block
`timescale 1ns/100ps
module tcs_timer_sync_bench;
  import tcs_pkg::*;
  // ****************************************
  // Design, partner and bus tasks
  // ****************************************
  logic         clk_sys_i;
  logic         rst_n_i;
  logic [7:0]   addr_i;
  tcs_word_type wdata_i;
  tcs_word_type rdata_o;
  logic         wr_i;
  logic         rd_i;
  logic         standby;
  logic         evt_start;
  logic         irq_o;
  logic         wake_o;
  logic         clk_req_o;
  logic         evt_ovf_o;
  int           failures = 0;
  int           samples_checked = 0;
  int           cycles = 0;
  tcs_timer_sync #(.NCH(2), .CORE_DIV(2)) i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .standby_i(standby), .evt_start_i(evt_start), .irq_o(irq_o), .wake_o(wake_o),
    .clk_req_o(clk_req_o), .evt_ovf_o(evt_ovf_o));
  tcs_evt_model i_evt (.clk_sys_i(clk_sys_i), .standby_o(standby), .evt_start_o(evt_start));
  task automatic give_verdict();
    $display("Compared %0d, mismatched %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input tcs_word_type got, input tcs_word_type exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Settle past the edge so registered outputs have landed
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : step
  // Burst of n back-to-back writes, data counting up
  task automatic wr(input logic [7:0] a, input tcs_word_type d, input int n = 1);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys_i);
      addr_i  <= a;
      wdata_i <= d + 16'(i);
      wr_i    <= 1'b1;
    end
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output tcs_word_type v);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd
  // Write, then read at once with no idle cycle between the two strobes
  task automatic wr_rd(input logic [7:0] a, input tcs_word_type d, input logic [7:0] ra,
                       output tcs_word_type v);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i   <= 1'b0;
    addr_i <= ra;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : wr_rd
  task automatic rchk(input logic [7:0] a, input tcs_word_type e, input tcs_word_type m);
    tcs_word_type v;
    rd(a, v);
    check(v & m, e);
  endtask : rchk
  // Poll the busy register, bounded, until bit b is clear
  task automatic sync_wait(input int b);
    tcs_word_type v;
    for (int i = 0; i < 30; i++) begin
      rd(8'h0C, v);
      if (v[b] === 1'b0) break;
    end
    check({15'h0000, v[b]}, 16'h0000);
  endtask : sync_wait
  function automatic logic pick(input int s);
    return (s == 0) ? evt_ovf_o : ((s == 1) ? clk_req_o : irq_o);
  endfunction : pick
  task automatic wait_on(input int s, input logic lvl, input int lim);
    #1;
    for (int n = 0; n < lim && pick(s) !== lvl; n++) step(1);
    check({15'h0000, pick(s)}, {15'h0000, lvl});
  endtask : wait_on
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rchk(8'h09, 16'h0000, 16'hFFFF);
    rchk(8'h0B, 16'h0001, 16'h0001);
    rchk(8'h3F, 16'h0000, 16'hFFFF);
    wr(8'h09, 16'h0013);
    rchk(8'h08, 16'h0013, 16'hFFFF);
    wr(8'h09, 16'h0000);
    rchk(8'h09, 16'h0013, 16'hFFFF);
    wr(8'h09, 16'h0020);
    rchk(8'h08, 16'h0033, 16'hFFFF);
    wr(8'h08, 16'h0033);
  endtask : t_regs
  task automatic t_sync();
    logic [7:0]   a [6] = '{8'h14, 8'h15, 8'h18, 8'h19, 8'h1C, 8'h1D};
    int           b [6] = '{5, 6, 7, 8, 9, 10};
    tcs_word_type d [6] = '{16'h0003, 16'h0003, 16'h0100, 16'h0101, 16'h0102, 16'h0103};
    tcs_word_type v;
    for (int i = 0; i < 6; i++) begin
      wr_rd(a[i], d[i], 8'h0C, v);
      check(v & 16'(1 << b[i]), 16'(1 << b[i]));
      sync_wait(b[i]);
      rchk(a[i], d[i], 16'hFFFF);
    end
  endtask : t_sync
  task automatic t_refuse();
    wr(8'h09, 16'h0002);
    wr(8'h14, 16'h0003, 2);
    rchk(8'h0A, 16'h0002, 16'h0002);
    check({15'h0000, irq_o}, 16'h0001);
    sync_wait(5);
    rchk(8'h14, 16'h0003, 16'hFFFF);
    wr(8'h0A, 16'h0002);
    step(3);
    check({15'h0000, irq_o}, 16'h0000);
    wr(8'h08, 16'h0002);
    wr(8'h14, 16'h0003, 2);
    rchk(8'h0A, 16'h0002, 16'h0002);
    check({15'h0000, irq_o}, 16'h0000);
    wr(8'h0A, 16'h0002);
  endtask : t_refuse
  task automatic t_read_sync_command();
    wr(8'h10, 16'h0055);
    sync_wait(4);
    rchk(8'h10, 16'h0000, 16'hFFFF);
    wr(8'h05, 16'h0080);
    sync_wait(2);
    rchk(8'h10, 16'h0055, 16'hFFFF);
    wr(8'h10, 16'h0000);
    sync_wait(4);
  endtask : t_read_sync_command
  task automatic t_clock_on_demand();
    wr(8'h05, 16'h0004);
    sync_wait(2);
    wr(8'h09, 16'h0001);
    wr(8'h00, 16'h0082);
    sync_wait(1);
    wait_on(0, 1'b1, 200);
    rchk(8'h0A, 16'h0001, 16'h0001);
    check({15'h0000, irq_o}, 16'h0001);
    wait_on(1, 1'b0, 20);
    rchk(8'h0B, 16'h0001, 16'h0001);
    i_evt.fire_start();
    wait_on(1, 1'b1, 6);
    wait_on(0, 1'b1, 100);
    wait_on(1, 1'b0, 20);
    wr(8'h0A, 16'h0001);
  endtask : t_clock_on_demand
  task automatic t_standby();
    int seen;
    seen = 0;
    wr(8'h04, 16'h0004);
    sync_wait(2);
    wr(8'h00, 16'h0002);
    i_evt.fire_start();
    wait_on(0, 1'b1, 100);
    i_evt.set_standby(1'b1);
    step(6);
    for (int n = 0; n < 60; n++) begin
      step(1);
      seen += int'(evt_ovf_o === 1'b1);
    end
    check(16'(seen), 16'h0000);
    check({15'h0000, wake_o}, 16'h0001);
    wr(8'h00, 16'h0042);
    wait_on(0, 1'b1, 100);
    i_evt.set_standby(1'b0);
  endtask : t_standby
  // Stop, retrigger, update commands, channel match gating, buffer valid clear
  task automatic t_cmds();
    wr(8'h05, 16'h0040);
    sync_wait(2);
    rchk(8'h0B, 16'h0001, 16'h0001);
    wr(8'h05, 16'h0020);
    sync_wait(2);
    rchk(8'h0B, 16'h0000, 16'h0001);
    wr(8'h08, 16'h0001);
    wr(8'h18, 16'h0002);
    sync_wait(7);
    wr(8'h0A, 16'h0013);
    step(12);
    check({15'h0000, irq_o}, 16'h0000);
    wr(8'h09, 16'h0010);
    wait_on(2, 1'b1, 20);
    rchk(8'h0A, 16'h0010, 16'h0010);
    wr(8'h05, 16'h0002);
    sync_wait(2);
    wr(8'h1C, 16'h0005);
    sync_wait(9);
    step(12);
    rchk(8'h0B, 16'h0010, 16'h0010);
    wr(8'h05, 16'h0060);
    sync_wait(2);
    rchk(8'h18, 16'h0005, 16'hFFFF);
    wr(8'h1C, 16'h0002);
    sync_wait(9);
    wr(8'h0B, 16'h0010);
    sync_wait(3);
    rchk(8'h0B, 16'h0000, 16'h0010);
  endtask : t_cmds
  task automatic t_softreset();
    wr(8'h00, 16'h0001);
    step(12);
    rchk(8'h09, 16'h0000, 16'hFFFF);
    rchk(8'h00, 16'h0000, 16'hFFFF);
    check({15'h0000, clk_req_o}, 16'h0000);
  endtask : t_softreset
  // Clock at 100 MHz
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Hang guard, far above the expected run length
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    addr_i  = 8'h00;
    wdata_i = 16'h0000;
    wr_i    = 1'b0;
    rd_i    = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    step(3);
    t_regs();
    t_sync();
    t_refuse();
    t_read_sync_command();
    t_clock_on_demand();
    t_standby();
    t_cmds();
    t_softreset();
    give_verdict();
  end
endmodule : tcs_timer_sync_bench
